//--- core/slp_edge_if.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Carries scan control and trigger settings to the selectable pulse
interface slp_edge_if;
    import slp_pkg::*;

    logic      scan_en;
    logic      scan_clr;
    logic      din;
    slp_edge_t edge_sel;
    slp_init_t init_sel;
    logic      cold_start;
    logic      warm_start;
    logic      pulse;

    modport edge_side (
        input  scan_en,
        input  scan_clr,
        input  din,
        input  edge_sel,
        input  init_sel,
        input  cold_start,
        input  warm_start,
        output pulse
    );

    modport blk_side (
        output scan_en,
        output scan_clr,
        output din,
        output edge_sel,
        output init_sel,
        output cold_start,
        output warm_start,
        input  pulse
    );
endinterface
`default_nettype wire

//--- core/slp_edge_pulse.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module slp_edge_pulse
    import slp_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // Scan side
    slp_edge_if.edge_side eif
);

    logic prev_r;
    logic prev_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic rise_hit;
    logic fall_hit;
    logic edge_hit;
    logic init_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Edge and initial-scan decode, next state
    always_comb begin
        prev_nxt  = prev_r;
        pulse_nxt = pulse_r;
        rise_hit  = eif.din & ~prev_r;
        fall_hit  = ~eif.din & prev_r;
        // RL6 trigger condition select
        case (eif.edge_sel)
            SLP_EDGE_RISE: edge_hit = rise_hit;
            SLP_EDGE_FALL: edge_hit = fall_hit;
            SLP_EDGE_BOTH: edge_hit = rise_hit | fall_hit;
            default:       edge_hit = 1'b0;
        endcase
        // RL8 initial scan options
        case (eif.init_sel)
            SLP_INIT_COLD: init_hit = eif.cold_start;
            SLP_INIT_WARM: init_hit = eif.warm_start;
            SLP_INIT_ANY:  init_hit = eif.cold_start | eif.warm_start;
            default:       init_hit = 1'b0;
        endcase
        // RL13 update only on scan or clear
        if (eif.scan_clr) begin
            prev_nxt  = OFF_VALUE;
            pulse_nxt = OFF_VALUE;
        end else if (eif.scan_en) begin
            // RL9 start pulse overrides edge
            // RL7 pulse lasts one scan
            pulse_nxt = init_hit | edge_hit;
            prev_nxt  = eif.din;
        end
    end

    // Registers only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_r  <= OFF_VALUE;
            pulse_r <= OFF_VALUE;
        end else begin
            prev_r  <= prev_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign eif.pulse = pulse_r;

    ////////////////////////////////////////////////////////////////////////////
    AST_TRIG_EDGE: assert property (@(posedge clk_sys) disable iff (rst) // RL6
        eif.scan_en && !eif.scan_clr && edge_hit |=> eif.pulse)
        else $error("selected edge gave no pulse");
    AST_TRIG_ONE: assert property (@(posedge clk_sys) disable iff (rst) // RL7
        eif.pulse && eif.scan_en && !eif.scan_clr && !init_hit && !edge_hit |=> !eif.pulse)
        else $error("pulse lasted beyond one scan");
    AST_TRIG_INIT: assert property (@(posedge clk_sys) disable iff (rst) // RL9
        eif.scan_en && !eif.scan_clr && init_hit |=> eif.pulse)
        else $error("start scan gave no pulse");
    AST_TRIG_NONE: assert property (@(posedge clk_sys) disable iff (rst) // RL8
        eif.scan_en && !eif.scan_clr && (eif.init_sel == SLP_INIT_NONE) && !edge_hit |=> !eif.pulse)
        else $error("pulse without edge with no start option");

endmodule // slp_edge_pulse
`default_nettype wire

//--- core/slp_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
package slp_pkg;

    // Bit positions of the eight-input OR
    localparam int unsigned OR_WIDTH       = 8;
    localparam int unsigned OR_INPUT_FIRST = 0;
    localparam int unsigned OR_INPUT_LAST  = 7;

    // Value of every stored bit after reset or scan clear
    localparam logic OFF_VALUE = 1'b0;

    // Trigger condition of the selectable pulse, one-hot
    typedef enum logic [2:0] {
        SLP_EDGE_RISE = 3'h1,
        SLP_EDGE_FALL = 3'h2,
        SLP_EDGE_BOTH = 3'h4
    } slp_edge_t;

    // Initial-scan behaviour of the selectable pulse, one-hot
    typedef enum logic [3:0] {
        SLP_INIT_NONE = 4'h1,
        SLP_INIT_COLD = 4'h2,
        SLP_INIT_WARM = 4'h4,
        SLP_INIT_ANY  = 4'h8
    } slp_init_t;

endpackage
`default_nettype wire

//--- core/slp_top.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1 - OR output ON if any of eight inputs ON, else OFF.
// RL2 - XOR output ON when exactly one of two inputs is ON.
// RL3 - Inverter output is the opposite of its input every scan.
// RL4 - Selector passes first data when control ON, otherwise second data.
// RL5 - Rising pulse ON one scan when input ON now, OFF last scan.
// RL6 - Selectable pulse triggers on rise, fall, or either edge.
// RL7 - Selectable pulse, once triggered, is ON one scan then OFF.
// RL8 - Start options: none, after cold, after warm, after either start.
// RL9 - Matching start type forces a pulse on first scan, edge ignored.
// RL10 - Latch sets ON with set ON and reset OFF, then stays ON.
// RL11 - Latch reset clears output only while set is OFF; both ON sets.
// RL12 - Latch holds previous output when set and reset both OFF.
// RL13 - All stored state moves only on scan enable, clears on clear.
// RL14 - Caller flags cold or warm start during first scan only.
////////////////////////////////////////////////////////////////////////////////
module slp_top
    import slp_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Scan control
    input  wire logic                scan_en,
    input  wire logic                scan_clr,
    input  wire logic                cold_start,
    input  wire logic                warm_start,
    // Eight-input OR
    input  wire logic [OR_WIDTH-1:0] or_in,
    output logic                     or_out,
    // Exclusive OR
    input  wire logic                xor_a,
    input  wire logic                xor_b,
    output logic                     xor_out,
    // Inverter
    input  wire logic                inv_in,
    output logic                     inv_out,
    // Selector
    input  wire logic                sel_first_data,
    input  wire logic                sel_second_data,
    input  wire logic                select_first_control,
    output logic                     sel_out,
    // Rising-edge pulse
    input  wire logic                rise_in,
    output logic                     rise_pulse,
    // Selectable pulse
    input  wire logic                trig_in,
    input  wire slp_edge_t           trig_edge_sel,
    input  wire slp_init_t           trig_init_sel,
    output logic                     trig_pulse,
    // Latch
    input  wire logic                latch_set,
    input  wire logic                latch_clr,
    output logic                     latch_out
);

    logic                or_r;
    logic                or_nxt;
    logic                xor_r;
    logic                xor_nxt;
    logic                inv_r;
    logic                inv_nxt;
    logic                sel_r;
    logic                sel_nxt;
    logic                rise_prev_r;
    logic                rise_prev_nxt;
    logic                rise_r;
    logic                rise_nxt;
    logic                latch_r;
    logic                latch_nxt;
    logic [OR_WIDTH-1:0] or_chain;

    ////////////////////////////////////////////////////////////////////////////
    // OR as a ripple chain, first input at the chain head
    // RL1 any input ON
    assign or_chain[OR_INPUT_FIRST] = or_in[OR_INPUT_FIRST];
    for (genvar gi = OR_INPUT_FIRST + 1; gi <= OR_INPUT_LAST; gi++) begin : g_or
        assign or_chain[gi] = or_chain[gi-1] | or_in[gi];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next values of all gate outputs; held between scans
    always_comb begin
        or_nxt        = or_r;
        xor_nxt       = xor_r;
        inv_nxt       = inv_r;
        sel_nxt       = sel_r;
        rise_prev_nxt = rise_prev_r;
        rise_nxt      = rise_r;
        latch_nxt     = latch_r;
        // RL13 clear beats scan
        if (scan_clr) begin
            or_nxt        = OFF_VALUE;
            xor_nxt       = OFF_VALUE;
            inv_nxt       = OFF_VALUE;
            sel_nxt       = OFF_VALUE;
            rise_prev_nxt = OFF_VALUE;
            rise_nxt      = OFF_VALUE;
            latch_nxt     = OFF_VALUE;
        end else if (scan_en) begin
            or_nxt        = or_chain[OR_INPUT_LAST];
            // RL2 exactly one ON
            xor_nxt       = xor_a ^ xor_b;
            // RL3 invert input
            inv_nxt       = ~inv_in;
            // RL4 select first or second
            if (select_first_control) begin
                sel_nxt = sel_first_data;
            end else begin
                sel_nxt = sel_second_data;
            end
            // RL5 one-scan rising pulse
            rise_nxt      = rise_in & ~rise_prev_r;
            rise_prev_nxt = rise_in;
            // RL10 set wins over reset
            if (latch_set) begin
                latch_nxt = 1'b1;
            // RL11 reset only with set OFF
            end else if (latch_clr) begin
                latch_nxt = 1'b0;
            end
            // RL12 otherwise hold
        end
    end

    // Registers only; async reset takes constants
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            or_r        <= OFF_VALUE;
            xor_r       <= OFF_VALUE;
            inv_r       <= OFF_VALUE;
            sel_r       <= OFF_VALUE;
            rise_prev_r <= OFF_VALUE;
            rise_r      <= OFF_VALUE;
            latch_r     <= OFF_VALUE;
        end else begin
            or_r        <= or_nxt;
            xor_r       <= xor_nxt;
            inv_r       <= inv_nxt;
            sel_r       <= sel_nxt;
            rise_prev_r <= rise_prev_nxt;
            rise_r      <= rise_nxt;
            latch_r     <= latch_nxt;
        end
    end

    // Data outputs straight from flops, so downstream sees stable values
    assign or_out     = or_r;
    assign xor_out    = xor_r;
    assign inv_out    = inv_r;
    assign sel_out    = sel_r;
    assign rise_pulse = rise_r;
    assign latch_out  = latch_r;

    ////////////////////////////////////////////////////////////////////////////
    // Selectable pulse; start flags trusted to last one scan only
    slp_edge_if u_eif ();

    // RL14 start flags forwarded
    assign u_eif.scan_en    = scan_en;
    assign u_eif.scan_clr   = scan_clr;
    assign u_eif.din        = trig_in;
    assign u_eif.edge_sel   = trig_edge_sel;
    assign u_eif.init_sel   = trig_init_sel;
    assign u_eif.cold_start = cold_start;
    assign u_eif.warm_start = warm_start;
    assign trig_pulse       = u_eif.pulse;

    slp_edge_pulse u_trig (
        .clk_sys (clk_sys),
        .rst     (rst),
        .eif     (u_eif.edge_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    AST_OR_ANY: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        scan_en && !scan_clr |=> or_out == (|$past(or_in)))
        else $error("OR output wrong after scan");
    AST_XOR_ONE: assert property (@(posedge clk_sys) disable iff (rst) // RL2
        scan_en && !scan_clr && (xor_a != xor_b) |=> xor_out)
        else $error("XOR output OFF with one input ON");
    AST_XOR_SAME: assert property (@(posedge clk_sys) disable iff (rst) // RL2
        scan_en && !scan_clr && (xor_a == xor_b) |=> !xor_out)
        else $error("XOR output ON with equal inputs");
    AST_INV_OPP: assert property (@(posedge clk_sys) disable iff (rst) // RL3
        scan_en && !scan_clr |=> inv_out != $past(inv_in))
        else $error("inverter output equals input");
    AST_SEL_PASS: assert property (@(posedge clk_sys) disable iff (rst) // RL4
        scan_en && !scan_clr |=> sel_out == ($past(select_first_control) ?
            $past(sel_first_data) : $past(sel_second_data)))
        else $error("selector passed the wrong input");
    AST_RISE_SEEN: assert property (@(posedge clk_sys) disable iff (rst) // RL5
        scan_en && !scan_clr && rise_in ##1 scan_en && !scan_clr && !rise_in
        ##1 scan_en && !scan_clr && rise_in |=> rise_pulse)
        else $error("rising edge gave no pulse");
    AST_RISE_ONCE: assert property (@(posedge clk_sys) disable iff (rst) // RL5
        rise_pulse && scan_en |=> !rise_pulse)
        else $error("rising pulse lasted beyond one scan");
    AST_LATCH_SET: assert property (@(posedge clk_sys) disable iff (rst) // RL10
        scan_en && !scan_clr && latch_set |=> latch_out)
        else $error("latch not set");
    AST_LATCH_CLR: assert property (@(posedge clk_sys) disable iff (rst) // RL11
        scan_en && !scan_clr && latch_clr && !latch_set |=> !latch_out)
        else $error("latch not cleared");
    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RL12
        scan_en && !scan_clr && !latch_clr && !latch_set |=> $stable(latch_out))
        else $error("latch changed without input");
    AST_SCAN_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RL13
        !scan_en && !scan_clr |=> $stable(or_out) && $stable(latch_out) && $stable(trig_pulse))
        else $error("state moved without scan");
    AST_SCAN_CLR: assert property (@(posedge clk_sys) disable iff (rst) // RL13
        scan_clr |=> !latch_out && !rise_pulse && !trig_pulse && !or_out)
        else $error("clear left state ON");

endmodule // slp_top
`default_nettype wire

//--- test/scan_logic_primitives_test.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module scan_logic_primitives_test;
    import slp_pkg::*;

    logic                clk_sys, rst, scan_en, scan_clr, cold_start, warm_start, cold_req, warm_req;
    logic [OR_WIDTH-1:0] or_in, s_or;
    logic                xor_a, xor_b, inv_in, sel_first_data, sel_second_data, select_first_control;
    logic                rise_in, trig_in, latch_set, latch_clr;
    logic                or_out, xor_out, inv_out, sel_out, rise_pulse, trig_pulse, latch_out;
    slp_edge_t           trig_edge_sel, s_edge;
    slp_init_t           trig_init_sel, s_init;
    // Staged values, copied onto the ports at the next rising edge
    logic                pend, s_clr, s_cold, s_warm, s_xa, s_xb, s_inv, s_sa, s_sb, s_sc, s_trig, s_ls, s_lc;
    logic                prev, cur, er, ef, et;
    int                  num_errors, n_checks;

    slp_top dut (.clk_sys(clk_sys), .rst(rst), .scan_en(scan_en), .scan_clr(scan_clr),
        .cold_start(cold_start), .warm_start(warm_start), .or_in(or_in), .or_out(or_out),
        .xor_a(xor_a), .xor_b(xor_b), .xor_out(xor_out), .inv_in(inv_in), .inv_out(inv_out),
        .sel_first_data(sel_first_data), .sel_second_data(sel_second_data),
        .select_first_control(select_first_control), .sel_out(sel_out), .rise_in(rise_in),
        .rise_pulse(rise_pulse), .trig_in(trig_in), .trig_edge_sel(trig_edge_sel),
        .trig_init_sel(trig_init_sel), .trig_pulse(trig_pulse), .latch_set(latch_set),
        .latch_clr(latch_clr), .latch_out(latch_out));

    slp_start_src u_start (.clk_sys(clk_sys), .rst(rst), .scan_en(scan_en), .cold_req(cold_req),
        .warm_req(warm_req), .cold_start(cold_start), .warm_start(warm_start));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 40 ns period
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Driver: staging is written at falling edges, so no race here
    always @(posedge clk_sys) begin
        scan_en <= pend;
        scan_clr <= s_clr;
        cold_req <= s_cold;
        warm_req <= s_warm;
        or_in <= s_or;
        {xor_a, xor_b, inv_in} <= {s_xa, s_xb, s_inv};
        {sel_first_data, sel_second_data, select_first_control} <= {s_sa, s_sb, s_sc};
        {rise_in, trig_in, latch_set, latch_clr} <= {s_trig, s_trig, s_ls, s_lc};
        trig_edge_sel <= s_edge;
        trig_init_sel <= s_init;
        pend = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // Results of a scan show one falling edge after the call returns, when the next call returns
    task scan;
        pend = 1'h1;
        @(negedge clk_sys);
    endtask

    task settle;
        @(negedge clk_sys);
    endtask

    // Clear raised together with a scan, so the clear must win
    task clear;
        s_clr = 1'h1;
        pend = 1'h1;
        @(negedge clk_sys);
        s_clr = 1'h0;
        @(negedge clk_sys);
    endtask

    task chk_edges;
        check(rise_pulse, er, "rise pulse");
        check(trig_pulse, et, "edge pulse");
    endtask

    task stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the 150 or so cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {pend, s_clr, s_cold, s_warm, s_xa, s_xb, s_inv, s_sa, s_sb, s_sc, s_trig, s_ls, s_lc} = '0;
        {scan_en, scan_clr, cold_req, warm_req, xor_a, xor_b, inv_in} = '0;
        {sel_first_data, sel_second_data, select_first_control, rise_in, trig_in, latch_set, latch_clr} = '0;
        s_or = 8'h00;
        or_in = 8'h00;
        s_edge = SLP_EDGE_RISE;
        trig_edge_sel = SLP_EDGE_RISE;
        s_init = SLP_INIT_NONE;
        trig_init_sel = SLP_INIT_NONE;
        num_errors = 0;
        n_checks = 0;
        rst = 1'h1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        @(negedge clk_sys);
        check(or_out | xor_out | inv_out | sel_out | rise_pulse | trig_pulse | latch_out, 1'h0, "reset");

        // Gates over every XOR, inverter and selector input combination; OR inputs one at a time, bit 7 included
        for (int v = 0; v < 16; v++) begin
            s_or = v[3] ? (8'h01 << v[2:0]) : 8'h00;
            {s_xa, s_xb, s_inv, s_sa, s_sb, s_sc} = {v[0], v[1], v[2], v[0], v[1], v[2]};
            scan();
            settle();
            check(or_out, v[3], "or");
            check(xor_out, v[0] ^ v[1], "xor");
            check(inv_out, !v[2], "inv");
            check(sel_out, v[2] ? v[0] : v[1], "select");
        end
        // Inputs move without a scan: outputs must hold
        s_or = 8'h00;
        s_inv = 1'h0;
        repeat (3) settle();
        check(or_out, 1'h1, "or hold");
        check(inv_out, 1'h0, "inv hold");
        clear();
        check(inv_out, 1'h0, "clear over scan");

        // Edge modes, plus an illegal code, scans back to back
        for (int m = 0; m < 4; m++) begin
            s_edge = (m == 3) ? slp_edge_t'(3'h0) : slp_edge_t'(3'h1 << m);
            clear();
            prev = 1'h0;
            for (int k = 0; k < 5; k++) begin
                // Input 1,0,1,1,0: rise, fall, rise back to back, then hold and fall
                cur = (k != 1) && (k != 4);
                s_trig = cur;
                scan();
                if (k > 0) chk_edges();
                er = cur & !prev;
                ef = !cur & prev;
                et = (m == 0 && er) || (m == 1 && ef) || (m == 2 && (er || ef));
                prev = cur;
            end
            settle();
            chk_edges();
        end

        // Start options against both start types, input held low
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                s_init = slp_init_t'(4'h1 << m);
                s_edge = SLP_EDGE_RISE;
                s_trig = 1'h0;
                clear();
                s_cold = (s == 0);
                s_warm = (s == 1);
                @(negedge clk_sys);
                {s_cold, s_warm} = 2'h0;
                scan();
                settle();
                check(trig_pulse, m == 3 || (m == 1 && s == 0) || (m == 2 && s == 1), "start");
                scan();
                settle();
                check(trig_pulse, 1'h0, "start once");
            end
        end

        // Latch: both, none, clear, none, set, clear
        for (int k = 0; k < 6; k++) begin
            s_ls = 6'h11 >> k;
            s_lc = 6'h25 >> k;
            scan();
            settle();
            check(latch_out, 6'h13 >> k & 1, "latch");
        end
        stop_test();
    end
endmodule // scan_logic_primitives_test
`default_nettype wire

//--- test/slp_start_src.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Surrounding logic that reports which start was just performed
module slp_start_src
    import slp_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Scan and start requests
    input  wire logic scan_en,
    input  wire logic cold_req,
    input  wire logic warm_req,
    // Start flags
    output logic      cold_start,
    output logic      warm_start
);
    logic cold_r;
    logic cold_nxt;
    logic warm_r;
    logic warm_nxt;

    // flag first scan only
    // Dropped by the scan that takes it, so a held flag never leaks on
    always_comb begin
        cold_nxt = scan_en ? OFF_VALUE : (cold_r | cold_req);
        warm_nxt = scan_en ? OFF_VALUE : (warm_r | warm_req);
    end

    // Flag registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cold_r <= 1'h0;
            warm_r <= 1'h0;
        end else begin
            cold_r <= cold_nxt;
            warm_r <= warm_nxt;
        end
    end

    assign cold_start = cold_r;
    assign warm_start = warm_r;
endmodule // slp_start_src
`default_nettype wire
